// ==== core/ptsi_params.svh ====
`ifndef PTSI_PARAMS_SVH
`define PTSI_PARAMS_SVH
// ==========================================================
// address map (byte addresses, 16-bit registers)
`define PTSI_TS_BASE        11'h400
`define PTSI_TS_END         11'h5FF
`define PTSI_RDY_OFS        11'h400
`define PTSI_EN_OFS         11'h402
`define PTSI_SWRST_OFS      11'h404
`define PTSI_RSV_LO         11'h406
`define PTSI_RSV_HI         11'h41F
`define PTSI_UNIT_BASE      11'h420
`define PTSI_UNIT_STRIDE    11'h028
`define PTSI_UNIT_STAT_OFS  11'h000
`define PTSI_UNIT_CFG_OFS   11'h002
`define PTSI_TRIG_BASE      11'h260
`define PTSI_TRIG_END       11'h398
`define PTSI_TRIG_RSV_HI    11'h3FF
`define PTSI_TRIG_USED_LEN  5'h18
`define PTSI_TRIG_SHIFT     5
`define PTSI_TRIG_FIRST     4'h3
// ==========================================================
// unit configuration fields
`define PTSI_CFG_SEL_LSB    8
`define PTSI_CFG_RISE_BIT   7
`define PTSI_CFG_FALL_BIT   6
`define PTSI_CFG_TAIL_BIT   5
`define PTSI_CFG_CASC_BIT   0
`define PTSI_SEL_MAX        4'h6
`define PTSI_CNT_MAX        4'hF
`define PTSI_RST_VAL        12'h000
`endif

// ==== core/ptsi_pkg.sv ====
package ptsi_pkg;
  // ==========================================================
  // address regions seen by the register port
  typedef enum logic [2:0]
  {
    PTSI_RG_NONE,
    PTSI_RG_RDY,
    PTSI_RG_EN,
    PTSI_RG_SWRST,
    PTSI_RG_STAT,
    PTSI_RG_CFG,
    PTSI_RG_TRIG,
    PTSI_RG_RSV
  } ptsi_region_t;
endpackage

// ==== core/ptsi_timestamp_input_control.sv ====
`timescale 1ns/1ps
`include "ptsi_params.svh"
// How it works
// R1: a unit that has caught an event raises its ready flag, and a ready unit drives the interrupt while the enable input is 1.
// R2: turning a unit's enable off clears its ready flag, so a disabled unit never reads ready.
// R3: ready, enable and soft reset each hold one bit per unit in bits 11..0, bit 0 for unit 1.
// R4: writing 1 to an enable bit enables the unit and zeroes its event counter.
// R5: writing 0 to an enable bit disables the unit and clears its ready and overflow flags.
// R6: writing 1 to a soft reset bit returns the unit to inactive defaults and the bit clears itself next cycle.
// R7: the time stamp input space spans 0x400 to 0x5FF and serves twelve units.
// R8: 0x406 to 0x41F is reserved and has no function.
// R9: trigger units 3 to 12 each own a 0x20 block from 0x260 up to 0x380.
// R10: the last eight bytes of each trigger block and 0x398 to 0x3FF are reserved.
// R11: each unit counts edges in four bits saturating at 15, then flags overflow, only the tail in cascade.
// R12: each unit picks one of seven pins by a four-bit selector, codes above 0110 unused.
// R13: rising and falling detection have separate enables and a disabled edge type is ignored.
// R14: bits 15..12 of ready, enable and soft reset read as zero and ignore writes.
module ptsi_timestamp_input_control
  import ptsi_pkg::*;
#(
  parameter int NUM_UNITS = 12,
  parameter int NUM_PINS  = 7
)
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                reg_cs,
  input  wire logic                reg_we,
  input  wire logic [10:0]         reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  output logic                     reg_ack,
  input  wire logic                timestamp_interrupt_enable,
  input  wire logic [NUM_PINS-1:0] gpio_in,
  output logic                     ts_irq,
  output logic                     trig_hit,
  output logic      [3:0]          trig_unit,
  output logic                     rsv_hit
);

  // ==========================================================
  // state
  logic [NUM_PINS-1:0]  gpio_s1_r;
  logic [NUM_PINS-1:0]  gpio_s2_r;
  logic [NUM_PINS-1:0]  gpio_d_r;
  logic [NUM_UNITS-1:0] unit_enable_bits_r;
  logic [NUM_UNITS-1:0] unit_soft_reset_bits_r;
  logic [NUM_UNITS-1:0] unit_ready_flags_r;
  logic [NUM_UNITS-1:0] event_count_overflow_r;
  logic [3:0]           detected_event_counter_r [NUM_UNITS];
  logic [11:0]          cfg_r [NUM_UNITS];
  logic [NUM_UNITS-1:0] ev;
  logic                 pin_now [NUM_UNITS];
  logic                 pin_old [NUM_UNITS];
  ptsi_region_t         region;
  logic [3:0]           unit_idx;
  logic                 wr;
  logic                 wr_en;
  logic [15:0]          rdata_nxt;

  // ==========================================================
  // address decode, shared by read and write paths
  function automatic ptsi_region_t decode(input logic [10:0] a, output logic [3:0] idx);
    logic [10:0] base;
    logic [10:0] rel;
    decode = PTSI_RG_NONE;
    idx    = 4'h0;
    base   = `PTSI_UNIT_BASE;
    rel    = a - `PTSI_TRIG_BASE;
    if (a == `PTSI_RDY_OFS) decode = PTSI_RG_RDY;
    else if (a == `PTSI_EN_OFS) decode = PTSI_RG_EN;
    else if (a == `PTSI_SWRST_OFS) decode = PTSI_RG_SWRST;
    else if (a >= `PTSI_RSV_LO && a <= `PTSI_RSV_HI) decode = PTSI_RG_RSV; // [R8]
    else if (a >= `PTSI_TRIG_BASE && a < `PTSI_TRIG_END)
    begin
      // trigger blocks: 0x18 bytes used, 8 bytes reserved at the tail
      idx = 4'(rel >> `PTSI_TRIG_SHIFT) + `PTSI_TRIG_FIRST; // [R9]
      decode = (rel[4:0] < `PTSI_TRIG_USED_LEN) ? PTSI_RG_TRIG : PTSI_RG_RSV; // [R10]
    end
    else if (a >= `PTSI_TRIG_END && a <= `PTSI_TRIG_RSV_HI) decode = PTSI_RG_RSV; // [R10]
    else if (a >= `PTSI_TS_BASE && a <= `PTSI_TS_END) // [R7]
    begin
      for (int i = 0; i < NUM_UNITS; i++)
      begin
        if (a == base + `PTSI_UNIT_STAT_OFS)
        begin
          decode = PTSI_RG_STAT;
          idx    = 4'(i);
        end
        if (a == base + `PTSI_UNIT_CFG_OFS)
        begin
          decode = PTSI_RG_CFG;
          idx    = 4'(i);
        end
        base = base + `PTSI_UNIT_STRIDE;
      end
    end
  endfunction

  always_comb
  begin
    region = decode(reg_addr, unit_idx);
    wr     = reg_cs & reg_we;
    wr_en  = wr && (region == PTSI_RG_EN);
  end

  // ==========================================================
  // pin synchroniser; the first stage feeds nothing but the second
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      gpio_s1_r <= '0;
      gpio_s2_r <= '0;
      gpio_d_r  <= '0;
    end
    else
    begin
      gpio_s1_r <= gpio_in;
      gpio_s2_r <= gpio_s1_r;
      gpio_d_r  <= gpio_s2_r;
    end
  end

  // ==========================================================
  // edge detection per unit; unused selector codes see no pin
  always_comb
  begin
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      pin_now[i] = 1'b0;
      pin_old[i] = 1'b0;
      if (cfg_r[i][`PTSI_CFG_SEL_LSB+:4] <= `PTSI_SEL_MAX) // [R12]
      begin
        pin_now[i] = gpio_s2_r[cfg_r[i][`PTSI_CFG_SEL_LSB+:3]];
        pin_old[i] = gpio_d_r[cfg_r[i][`PTSI_CFG_SEL_LSB+:3]];
      end
      ev[i] = unit_enable_bits_r[i] & ~unit_soft_reset_bits_r[i]
            & ((cfg_r[i][`PTSI_CFG_RISE_BIT] & pin_now[i] & ~pin_old[i])
            | (cfg_r[i][`PTSI_CFG_FALL_BIT] & ~pin_now[i] & pin_old[i])); // [R13]
    end
  end

  // ==========================================================
  // enable bits; soft reset forces the unit inactive
  always_ff @(posedge ref_clk)
  begin
    if (rst) unit_enable_bits_r <= `PTSI_RST_VAL;
    else
    begin
      for (int i = 0; i < NUM_UNITS; i++)
      begin
        if (unit_soft_reset_bits_r[i]) unit_enable_bits_r[i] <= 1'b0; // [R6]
        else if (wr_en) unit_enable_bits_r[i] <= reg_wdata[i]; // [R3] [R4] [R5] [R14]
      end
    end
  end

  // ==========================================================
  // soft reset bits live one cycle, long enough to clear the unit
  always_ff @(posedge ref_clk)
  begin
    if (rst) unit_soft_reset_bits_r <= `PTSI_RST_VAL;
    else if (wr && region == PTSI_RG_SWRST) unit_soft_reset_bits_r <= reg_wdata[11:0]; // [R6]
    else unit_soft_reset_bits_r <= `PTSI_RST_VAL; // [R6]
  end

  // ==========================================================
  // unit configuration; reset to default by soft reset
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (rst || unit_soft_reset_bits_r[i]) cfg_r[i] <= `PTSI_RST_VAL; // [R6]
      else if (wr && region == PTSI_RG_CFG && unit_idx == 4'(i)) cfg_r[i] <= reg_wdata[11:0];
    end
  end

  // ==========================================================
  // ready, counter and overflow; the enable write wins over an event in the same cycle, except that a write of 0 still lets the counter count it
  always_ff @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (rst || unit_soft_reset_bits_r[i])
      begin
        unit_ready_flags_r[i]       <= 1'b0; // [R6]
        event_count_overflow_r[i]   <= 1'b0;
        detected_event_counter_r[i] <= 4'h0;
      end
      else
      begin
        if (wr_en && !reg_wdata[i]) unit_ready_flags_r[i] <= 1'b0; // [R2] [R5]
        else if (ev[i]) unit_ready_flags_r[i] <= 1'b1; // [R1]
        if (wr_en && reg_wdata[i]) detected_event_counter_r[i] <= 4'h0; // [R4]
        else if (ev[i] && detected_event_counter_r[i] != `PTSI_CNT_MAX)
          detected_event_counter_r[i] <= detected_event_counter_r[i] + 4'h1; // [R11]
        if (wr_en && !reg_wdata[i]) event_count_overflow_r[i] <= 1'b0; // [R5]
        else if (ev[i] && !wr_en && detected_event_counter_r[i] == `PTSI_CNT_MAX
                 && (!cfg_r[i][`PTSI_CFG_CASC_BIT] || cfg_r[i][`PTSI_CFG_TAIL_BIT]))
          event_count_overflow_r[i] <= 1'b1; // [R11]
      end
    end
  end

  // ==========================================================
  // read mux; reserved and unmapped space reads zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    unique case (region)
      PTSI_RG_RDY:   rdata_nxt = {4'h0, unit_ready_flags_r}; // [R3] [R14]
      PTSI_RG_EN:    rdata_nxt = {4'h0, unit_enable_bits_r}; // [R14]
      PTSI_RG_SWRST: rdata_nxt = {4'h0, unit_soft_reset_bits_r}; // [R14]
      PTSI_RG_STAT:  rdata_nxt = {11'h000, detected_event_counter_r[unit_idx],
                                  event_count_overflow_r[unit_idx]};
      PTSI_RG_CFG:   rdata_nxt = {4'h0, cfg_r[unit_idx]};
      PTSI_RG_TRIG, PTSI_RG_RSV, PTSI_RG_NONE: rdata_nxt = 16'h0000;
    endcase
  end

  // ==========================================================
  // registered answer and trigger-space report, one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_ack   <= 1'b0;
      reg_rdata <= 16'h0000;
      trig_hit  <= 1'b0;
      trig_unit <= 4'h0;
      rsv_hit   <= 1'b0;
    end
    else
    begin
      reg_ack   <= reg_cs;
      reg_rdata <= reg_cs ? rdata_nxt : 16'h0000;
      trig_hit  <= reg_cs && region == PTSI_RG_TRIG; // [R9]
      trig_unit <= (reg_cs && region == PTSI_RG_TRIG) ? unit_idx : 4'h0;
      rsv_hit   <= reg_cs && region == PTSI_RG_RSV; // [R8] [R10]
    end
  end

  // ==========================================================
  // interrupt: level while any ready unit is unmasked
  always_ff @(posedge ref_clk)
  begin
    if (rst) ts_irq <= 1'b0;
    else ts_irq <= |(unit_ready_flags_r & {NUM_UNITS{timestamp_interrupt_enable}}); // [R1]
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_irq;
    unit_ready_flags_r[0] && timestamp_interrupt_enable |=> ts_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("ready unit did not interrupt"); // [R1]
  property p_dis_not_rdy;
    !unit_enable_bits_r[0] |-> !unit_ready_flags_r[0];
  endproperty
  a_dis_not_rdy: assert property (p_dis_not_rdy) else $error("disabled unit ready"); // [R2]
  property p_en_clr_cnt;
    wr_en && reg_wdata[0] && !unit_soft_reset_bits_r[0] |=>
      detected_event_counter_r[0] == 4'h0 && unit_enable_bits_r[0];
  endproperty
  a_en_clr_cnt: assert property (p_en_clr_cnt) else $error("enable kept count"); // [R4]
  property p_dis_clr;
    wr_en && !reg_wdata[0] |=> !event_count_overflow_r[0] && !unit_ready_flags_r[0];
  endproperty
  a_dis_clr: assert property (p_dis_clr) else $error("disable kept flags"); // [R5]
  property p_swrst;
    unit_soft_reset_bits_r[0] && !(wr && region == PTSI_RG_SWRST) |=>
      !unit_soft_reset_bits_r[0] && !unit_enable_bits_r[0] && cfg_r[0] == 12'h000;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset misbehaved"); // [R6]
  property p_ovf_sat;
    $rose(event_count_overflow_r[0]) |-> detected_event_counter_r[0] == 4'hF;
  endproperty
  a_ovf_sat: assert property (p_ovf_sat) else $error("overflow before 15"); // [R11]
  property p_sel;
    ev[0] |-> cfg_r[0][11:8] <= 4'h6;
  endproperty
  a_sel: assert property (p_sel) else $error("event on unused selector"); // [R12]
  property p_edge;
    ev[0] && !cfg_r[0][`PTSI_CFG_RISE_BIT] |-> !pin_now[0] && pin_old[0];
  endproperty
  a_edge: assert property (p_edge) else $error("masked edge counted"); // [R13]
  property p_rsv_bits;
    reg_ack |-> reg_rdata[15:12] == 4'h0;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("reserved bits nonzero"); // [R14]
  property p_trig;
    trig_hit |-> trig_unit >= 4'h3 && trig_unit <= 4'hC && !rsv_hit;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger unit out of range"); // [R9]
  c_event: cover property (ev[0] ##1 unit_ready_flags_r[0]);
  c_ovf: cover property ($rose(event_count_overflow_r[0]));
  c_swrst: cover property (unit_soft_reset_bits_r[0]);
  c_irq: cover property ($rose(ts_irq));

endmodule

// ==== tb/ptsi_testbench.sv ====
`timescale 1ns/1ps
// ==========================================================
// bench for the time stamp input control block
module testbench;
  import ptsi_pkg::*;
  logic        ref_clk;
  logic        rst;
  logic        reg_cs;
  logic        reg_we;
  logic [10:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        ts_ie;
  logic [6:0]  gpio_in;
  logic        ts_irq;
  logic        trig_hit;
  logic [3:0]  trig_unit;
  logic        rsv_hit;
  logic [15:0] rd;
  logic        th;
  logic [3:0]  tu;
  logic        rh;
  int          miscompares;
  int          n_compared;
  int          cycles = 0;

  ptsi_timestamp_input_control dut_u (
    .ref_clk                    (ref_clk),
    .rst                        (rst),
    .reg_cs                     (reg_cs),
    .reg_we                     (reg_we),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_rdata                  (reg_rdata),
    .reg_ack                    (reg_ack),
    .timestamp_interrupt_enable (ts_ie),
    .gpio_in                    (gpio_in),
    .ts_irq                     (ts_irq),
    .trig_hit                   (trig_hit),
    .trig_unit                  (trig_unit),
    .rsv_hit                    (rsv_hit)
  );

  // ==========================================================
  // clock and hang guard; ceiling is far above the few hundred cycles used
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // one register access; answer is taken the cycle after the strobe
  task automatic acc(input logic we, input logic [10:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_cs    <= 1'b1;
    reg_we    <= we;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_cs <= 1'b0;
    #1;
    rd = reg_rdata;
    th = trig_hit;
    tu = trig_unit;
    rh = rsv_hit;
    chk({15'h0000, reg_ack}, 16'h0001);
  endtask

  task automatic rchk(input logic [10:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask

  // toggle pins and leave time for the synchroniser and edge compare
  task automatic pins(input logic [6:0] m, input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      gpio_in <= gpio_in ^ m;
      repeat (5) @(posedge ref_clk);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset_and_width();
    rchk(11'h400, 16'h0000);
    rchk(11'h404, 16'h0000);
    acc(1'b1, 11'h402, 16'hFFFF);
    rchk(11'h402, 16'h0FFF);
    acc(1'b1, 11'h400, 16'hFFFF);
    rchk(11'h400, 16'h0000);
    acc(1'b1, 11'h402, 16'h0000);
  endtask

  task automatic t_events();
    acc(1'b1, 11'h422, 16'h0080);
    acc(1'b1, 11'h5DA, 16'h0680);
    acc(1'b1, 11'h402, 16'h0801);
    @(posedge ref_clk) ts_ie <= 1'b1;
    pins(7'h41, 1);
    rchk(11'h400, 16'h0801);
    chk({15'h0000, ts_irq}, 16'h0001);
    rchk(11'h420, 16'h0002);
    pins(7'h41, 1);
    rchk(11'h420, 16'h0002);
    @(posedge ref_clk) ts_ie <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, ts_irq}, 16'h0000);
    acc(1'b1, 11'h402, 16'h0800);
    rchk(11'h400, 16'h0800);
    acc(1'b1, 11'h402, 16'h0000);
    rchk(11'h400, 16'h0000);
  endtask

  task automatic t_overflow();
    acc(1'b1, 11'h422, 16'h00E0);
    acc(1'b1, 11'h402, 16'h0001);
    rchk(11'h420, 16'h0000);
    pins(7'h01, 16);
    rchk(11'h420, 16'h001F);
    acc(1'b1, 11'h402, 16'h0001);
    rchk(11'h420, 16'h0001);
    acc(1'b1, 11'h402, 16'h0000);
    rchk(11'h420, 16'h0000);
    // cascade without tail: count saturates but overflow stays clear
    acc(1'b1, 11'h422, 16'h00C1);
    acc(1'b1, 11'h402, 16'h0001);
    pins(7'h01, 16);
    rchk(11'h420, 16'h001E);
    acc(1'b1, 11'h402, 16'h0000);
  endtask

  task automatic t_unused_select();
    acc(1'b1, 11'h422, 16'h07C0);
    acc(1'b1, 11'h402, 16'h0001);
    pins(7'h7F, 2);
    rchk(11'h420, 16'h0000);
    rchk(11'h400, 16'h0000);
  endtask

  task automatic t_soft_reset();
    acc(1'b1, 11'h422, 16'h0080);
    acc(1'b1, 11'h402, 16'h0001);
    acc(1'b1, 11'h404, 16'hF001);
    repeat (2) @(posedge ref_clk);
    rchk(11'h404, 16'h0000);
    rchk(11'h402, 16'h0000);
    rchk(11'h422, 16'h0000);
  endtask

  task automatic t_map();
    logic [10:0] b;
    for (int u = 3; u <= 12; u++)
    begin
      b = 11'h260 + 11'(u - 3) * 11'h020;
      rchk(b, 16'h0000);
      chk({15'h0000, th}, 16'h0001);
      chk({12'h000, tu}, 16'(u));
      acc(1'b0, b + 11'h016, 16'h0000);
      chk({12'h000, tu}, 16'(u));
      acc(1'b0, b + 11'h018, 16'h0000);
      chk({14'h0000, th, rh}, 16'h0001);
    end
    acc(1'b0, 11'h398, 16'h0000);
    chk({15'h0000, rh}, 16'h0001);
    acc(1'b0, 11'h3FE, 16'h0000);
    chk({15'h0000, rh}, 16'h0001);
    rchk(11'h406, 16'h0000);
    chk({15'h0000, rh}, 16'h0001);
    acc(1'b0, 11'h41E, 16'h0000);
    chk({15'h0000, rh}, 16'h0001);
    rchk(11'h600, 16'h0000);
    chk({14'h0000, th, rh}, 16'h0000);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    ref_clk     = 1'b0;
    rst         = 1'b1;
    reg_cs      = 1'b0;
    reg_we      = 1'b0;
    reg_addr    = 11'h000;
    reg_wdata   = 16'h0000;
    ts_ie       = 1'b0;
    gpio_in     = 7'h00;
    miscompares = 0;
    n_compared  = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_and_width();
    t_events();
    t_overflow();
    t_unused_select();
    t_soft_reset();
    t_map();
    finish_test();
  end
endmodule
